/* dv/led_buck_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module led_buck_chk
   import led_buck_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic supply_dimming_input,
   input wire logic [REF_W-1:0] thermal_reference_pin,
   input wire logic [REF_W-1:0] current_reference_pin,
   input wire logic [REF_W-1:0] voltage_reference_pin,
   input wire logic [SENSE_W-1:0] current_sense_input,
   input wire logic gate_drive,
   input wire logic on_timer_running
);
   logic [REF_W-1:0] m, th;
   logic [15:0] on_c, off_c, hi_c, tm_c;
   logic ran;
   wire logic en = supply_dimming_input;
   assign m = thermal_reference_pin < current_reference_pin ? thermal_reference_pin : current_reference_pin;
   assign th = REF_W'((m < voltage_reference_pin ? m : voltage_reference_pin) / REF_DIV);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Ran clears with the enable, so a restart is not judged as an off phase
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {on_c, off_c, hi_c, tm_c, ran} <= 65'h0;
      end else begin
         on_c <= gate_drive ? on_c + 16'h1 : 16'h0;
         off_c <= gate_drive ? 16'h0 : off_c + 16'h1;
         hi_c <= current_sense_input >= th ? hi_c + 16'h1 : 16'h0;
         tm_c <= on_timer_running ? tm_c + 16'h1 : 16'h0;
         ran <= en && (ran || gate_drive);
      end
   end
   ////////////////////////////////////////
   AST_START: assert property ((en && !ran) [*8] |-> gate_drive) else $error("no turn-on");
   AST_DARK: assert property (!en [*7] |-> !gate_drive) else $error("gate on while off");
   AST_BLANK: assert property ($fell(gate_drive) && en |-> on_c >= 16'h19) else $error("off in blanking");
   AST_CAUSE: assert property ($fell(gate_drive) && en |-> hi_c >= 16'h24 || $past(tm_c) >= 16'h1C0C)
      else $error("off without cause");
   AST_PEAK: assert property (hi_c == 16'h24 && on_c > 16'h46 |-> ##[0:10] !gate_drive) else $error("peak missed");
   AST_OFF_MIN: assert property ($rose(gate_drive) && ran |-> off_c >= 16'h3E0) else $error("off short");
   AST_OFF_MAX: assert property (ran |-> off_c <= 16'h5DC) else $error("off long");
   AST_LIMIT: assert property (on_timer_running |-> tm_c <= 16'h1C5E) else $error("on limit missed");
endmodule : led_buck_chk
bind led_buck_switch_timing_control led_buck_chk i_led_buck_chk (.clk, .rst_b, .supply_dimming_input,
   .thermal_reference_pin, .current_reference_pin, .voltage_reference_pin, .current_sense_input,
   .gate_drive, .on_timer_running);
`default_nettype wire

/* dv/led_buck_switch_timing_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module led_buck_switch_timing_control_tb
   import led_buck_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, ring = 1'b0, gate, tmr;
   logic [REF_W-1:0] r_th = 12'hBB8, r_cu = 12'hBB8, r_vo = 12'h3E8;
   logic [SENSE_W-1:0] sense, cap = 12'hFA0;
   int num_errors = 0, compares = 0;
   initial forever #4 clk = ~clk;
   led_buck_switch_timing_control i_led_buck_switch_timing_control (.clk, .rst_b, .supply_dimming_input(en),
      .thermal_reference_pin(r_th), .current_reference_pin(r_cu), .voltage_reference_pin(r_vo),
      .current_sense_input(sense), .gate_drive(gate), .on_timer_running(tmr));
   led_coil_model i_led_coil_model (.clk, .rst_b, .gate_drive(gate), .ring, .cap, .current_sense_input(sense));
   ////////////////////////////////////////
   task automatic chk(input string what, input int lo, input int hi, input int got);
      compares++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk
   task automatic wait_gate(input logic v, output int n);
      n = 0;
      while (gate !== v && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_gate
   task automatic close_out;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////
   task automatic t_peak;
      int on_t, n, th, e;
      int off_t[3];
      ring = 1'b1;
      for (int i = 0; i < 3; i++) begin
         th = 1000 + 250 * i;
         r_th = i == 0 ? th[11:0] : 12'hBB8;
         r_cu = i == 1 ? th[11:0] : 12'hBB8;
         r_vo = i == 2 ? th[11:0] : 12'hBB8;
         wait_gate(1'b0, n);
         wait_gate(1'b1, n);
         wait_gate(1'b0, on_t);
         wait_gate(1'b1, off_t[i]);
         e = th / REF_DIV / 2 + DEBOUNCE_CYC;
         chk("on time", e - 2, e + 8, on_t);
         chk("off time", 16 * HALF_TICK_DIV, 24 * HALF_TICK_DIV + 8, off_t[i]);
      end
      chk("off jitter", 1, 1, int'(off_t[0] != off_t[1] || off_t[1] != off_t[2]));
      $display("test peak done");
   endtask : t_peak
   task automatic t_limit;
      int on_t, n;
      ring = 1'b0;
      cap = 12'h096;
      r_vo = 12'h3E8;
      wait_gate(1'b0, n);
      wait_gate(1'b1, n);
      repeat (200) @(posedge clk);
      #1;
      chk("timer running", 1, 1, int'(tmr === 1'b1));
      wait_gate(1'b0, on_t);
      on_t += 200;
      chk("on limit", 50 + 116 * HALF_TICK_DIV, 58 + 117 * HALF_TICK_DIV + DEBOUNCE_CYC, on_t);
      $display("test limit done");
   endtask : t_limit
   task automatic t_dim;
      int n;
      en = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      n = 0;
      repeat (300) begin
         @(posedge clk);
         #1;
         n += int'(gate !== 1'b0);
      end
      chk("gate while off", 0, 0, n);
      en = 1'b1;
      wait_gate(1'b1, n);
      chk("restart", 1, 8, n);
      $display("test dim done");
   endtask : t_dim
   ////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      t_peak();
      t_limit();
      t_dim();
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      close_out();
   end
endmodule : led_buck_switch_timing_control_tb
`default_nettype wire

/* dv/led_coil_model.sv */
`timescale 1ns/1ps
`default_nettype none
module led_coil_model
   import led_buck_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic gate_drive,
   input wire logic ring,
   input wire logic [SENSE_W-1:0] cap,
   output logic [SENSE_W-1:0] current_sense_input
);
   logic [SENSE_W-1:0] level;
   logic [5:0] age;
   // Ramp 2 per cycle while on, bleed 1 while off; cap mimics a weak supply
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {level, age} <= 18'h0;
      end else begin
         age <= gate_drive ? age + {5'h00, age != 6'h3F} : 6'h00;
         if (gate_drive) level <= level + 12'h002 > cap ? cap : level + 12'h002;
         else if (level != 12'h000) level <= level - 12'h001;
      end
   end
   // Ringing spikes, shorter than the debounce
   assign current_sense_input = ring && gate_drive && (age < 6'h14 || (age > 6'h1B && age < 6'h28)) ? 12'hFA0 : level;
endmodule : led_coil_model
`default_nettype wire

/* verilog/led_buck_pkg.sv */
package led_buck_pkg;
   // Oscillator runs at 1 MHz nominal; half-period ticks at 2 MHz
   localparam int CLK_HZ = 125000000;
   localparam int OSC_HZ = 1000000;
   localparam int HALF_TICK_DIV = CLK_HZ / (2 * OSC_HZ);
   localparam int HALF_TICK_W = 7;
   // Times in ns
   localparam int DEBOUNCE_NS = 300;
   localparam int BLANK_MIN_NS = 200;
   localparam int CLK_PERIOD_NS = 8;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYC = (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 8;
   // Half-ticks: 58.5 clocks -> 117, 10.5 pulses -> 21
   localparam logic [TIMER_W-1:0] ON_LIMIT_HALF = 8'h75;
   localparam logic [TIMER_W-1:0] OFF_NOM_HALF = 8'h15;
   // Shortest off count; the 3-bit jitter value 0..7 is added on top of it
   localparam logic [TIMER_W-1:0] OFF_BASE_HALF = 8'h11;
   localparam int LFSR_W = 5;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 5'h01;
   localparam int REF_W = 12;
   localparam int REF_DIV = 5;
   localparam int SENSE_W = 12;
endpackage : led_buck_pkg

/* verilog/led_buck_switch_timing_control.sv */
// Overview of operation
// - After power-up and while enabled the gate is driven on so the coil current rises.
// - At half the peak threshold an on timer starts and the gate turns off after 58.5 oscillator clocks.
// - The peak threshold is the lowest of three reference inputs divided by five.
// - After each switch-off the gate stays off for 10.5 oscillator pulses nominal, then turns on again.
// - Reaching the peak threshold ends the on phase and starts the off phase.
// - The peak comparison is debounced for 300 ns against switching ringing; the half-threshold comparison is not.
// - Low dimming input keeps the LED off, high runs it, a pulse train dims it.
// - The on-time limit caps duty cycle near 85% when the peak is never reached.
// - A pseudo-random generator stepped once per off phase adds its low 3 bits (0..7) to the off count.
// - The sense comparison is ignored for a blanking time of 200 ns (25 clocks) after turn-on.
`timescale 1ns/1ps
`default_nettype none
module led_buck_switch_timing_control
   import led_buck_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic supply_dimming_input,
   input wire logic [REF_W-1:0] thermal_reference_pin,
   input wire logic [REF_W-1:0] current_reference_pin,
   input wire logic [REF_W-1:0] voltage_reference_pin,
   input wire logic [SENSE_W-1:0] current_sense_input,
   output logic gate_drive,
   output logic on_timer_running
);
   typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} phase_e;

   logic enable;
   logic half_tick;
   logic [HALF_TICK_W-1:0] div_cnt;
   logic [REF_W-1:0] ref_min;
   logic [REF_W-1:0] peak_thr;
   logic [REF_W-1:0] half_thr;
   logic raw_peak;
   logic raw_half;
   logic deb_peak;
   logic [5:0] deb_cnt;
   logic [5:0] blank_cnt;
   logic blanking;
   phase_e phase;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] off_len;
   logic [LFSR_W-1:0] lfsr;
   logic [LFSR_W-1:0] next_lfsr;
   logic on_limit_hit;
   logic switch_off;
   logic timer_start;
   logic off_done;

   ////////////////////////////////////////////////////////////////////////
   pin_filter u_pwm_filter (
      .clk(clk),
      .rst_b(rst_b),
      .pin(supply_dimming_input),
      .level(enable)
   );

   ////////////////////////////////////////////////////////////////////////
   // Half-period tick of the oscillator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= '0;
         half_tick <= 1'b0;
      end else if (div_cnt == HALF_TICK_W'(HALF_TICK_DIV - 1)) begin
         div_cnt <= '0;
         half_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         half_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      ref_min = thermal_reference_pin;
      if (current_reference_pin < ref_min) begin
         ref_min = current_reference_pin;
      end
      if (voltage_reference_pin < ref_min) begin
         ref_min = voltage_reference_pin;
      end
   end

   assign peak_thr = REF_W'(ref_min / REF_DIV);
   assign half_thr = peak_thr >> 1;
   assign raw_peak = (current_sense_input >= peak_thr);
   assign raw_half = (current_sense_input >= half_thr);
   assign blanking = (blank_cnt != 6'(BLANK_CYC));

   // Blanking counter restarts on each turn-on
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blank_cnt <= '0;
      end else if (phase != ST_ON) begin
         blank_cnt <= '0;
      end else if (blanking) begin
         blank_cnt <= blank_cnt + 1'b1;
      end
   end

   // Peak must hold steadily for the debounce time
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         deb_cnt <= '0;
         deb_peak <= 1'b0;
      end else if (!raw_peak || blanking) begin
         deb_cnt <= '0;
         deb_peak <= 1'b0;
      end else if (deb_cnt != 6'(DEBOUNCE_CYC)) begin
         deb_cnt <= deb_cnt + 1'b1;
         deb_peak <= 1'b0;
      end else begin
         deb_peak <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Peak wins over the on limit when both land in one cycle
   assign on_limit_hit = on_timer_running && (timer == ON_LIMIT_HALF);
   assign switch_off = (phase == ST_ON) && enable && (deb_peak || on_limit_hit);

   // Blanked like the peak, so turn-on ringing cannot arm the limit early
   assign timer_start = (phase == ST_ON) && enable && !on_timer_running && raw_half && !blanking;
   assign off_done = (phase == ST_OFF) && enable && (timer >= off_len);

   ////////////////////////////////////////////////////////////////////////
   // LFSR x^5+x^3+1, steps once per switch-off
   assign next_lfsr = {lfsr[LFSR_W-2:0], lfsr[4] ^ lfsr[2]};

   // Zero guard costs one compare and rules out a stuck generator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr <= LFSR_SEED;
      end else if (lfsr == '0) begin
         lfsr <= LFSR_SEED;
      end else if (switch_off) begin
         lfsr <= next_lfsr;
      end
   end

   // Nominal 21 half-ticks; low bits spread 17..24
   assign off_len = OFF_BASE_HALF + TIMER_W'(lfsr[2:0]);

   ////////////////////////////////////////////////////////////////////////
   // On-time limit runs from half threshold until the phase ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         on_timer_running <= 1'b0;
      end else if (phase != ST_ON || !enable || switch_off) begin
         on_timer_running <= 1'b0;
      end else if (timer_start) begin
         on_timer_running <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One timer shared: on limit while on, monoflop while off
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer <= '0;
      end else if (phase == ST_IDLE || switch_off || timer_start || off_done) begin
         timer <= '0;
      end else if (half_tick && phase == ST_OFF) begin
         timer <= timer + 1'b1;
      end else if (half_tick && on_timer_running) begin
         timer <= timer + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= ST_IDLE;
      end else begin
         case (phase)
            ST_IDLE: begin
               if (enable) begin
                  phase <= ST_ON;
               end
            end
            ST_ON: begin
               if (!enable) begin
                  phase <= ST_IDLE;
               end else if (deb_peak) begin
                  phase <= ST_OFF;
               end else if (on_limit_hit) begin
                  phase <= ST_OFF;
               end
            end
            ST_OFF: begin
               if (!enable) begin
                  phase <= ST_IDLE;
               end else if (off_done) begin
                  phase <= ST_ON;
               end
            end
            default: begin
               phase <= ST_IDLE;
            end
         endcase
      end
   end

   // Gate registered for a glitch-free driver input
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_drive <= 1'b0;
      end else begin
         gate_drive <= (phase == ST_ON) && enable;
      end
   end
endmodule : led_buck_switch_timing_control
`default_nettype wire

/* verilog/pin_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_filter
   import led_buck_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Level follows s3 only once two settled stages agree
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule : pin_filter
`default_nettype wire
